//--- verilog/pdom_regs.vh
// register offsets, field layouts and timing constants of the process data object (PDO) mapper
`ifndef PDOM_REGS_VH
`define PDOM_REGS_VH

// ----------------------------------------------------------------
// register map (byte addresses, one word each)
// ----------------------------------------------------------------
`define PDOM_CTRL_ADDR   12'h000
`define PDOM_STAT_ADDR   12'h004
`define PDOM_SEL_ADDR    12'h008
`define PDOM_ID_ADDR     12'h00C
`define PDOM_CFG_ADDR    12'h010
`define PDOM_SLOTLO_ADDR 12'h014
`define PDOM_SLOTHI_ADDR 12'h018
`define PDOM_TIME_ADDR   12'h01C
`define PDOM_MEMA_ADDR   12'h020
`define PDOM_MEMD_ADDR   12'h024
`define PDOM_RXCNT_ADDR  12'h028
`define PDOM_TXCNT_ADDR  12'h02C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PDOM_CTRL_EN_BIT   0
`define PDOM_SEL_TX_BIT    7
`define PDOM_CFG_LEN_LSB   0
`define PDOM_CFG_SLV_LSB   8
`define PDOM_CFG_CHG_BIT   16
`define PDOM_CFG_EN_BIT    17
`define PDOM_STAT_BAD_BIT  0
`define PDOM_STAT_BUSY_BIT 1

// ----------------------------------------------------------------
// reset values, length limits and timing
// ----------------------------------------------------------------
`define PDOM_CTRL_RST    1'b0
`define PDOM_LEN_MIN     4'h1
`define PDOM_LEN_MAX     4'h8
`define PDOM_CLK_HZ      20000000
`define PDOM_MS_HZ       1000
`define PDOM_MS_CYC      (`PDOM_CLK_HZ / `PDOM_MS_HZ)

`endif

//--- verilog/pdom_mapper.v
// process data object mapper between CAN frames and fieldbus slave data arrays
`timescale 1ns/1ps
`include "pdom_regs.vh"

module pdom_mapper #(
  parameter NENT   = 30,
  parameter NSLV   = 4,
  parameter MS_CYC = `PDOM_MS_CYC
) (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // can receive frame, one-cycle strobe
  input  wire        rx_valid_i,
  input  wire [10:0] rx_id_i,
  input  wire [63:0] rx_data_i,
  // can transmit frame, held until accepted
  output reg         tx_valid_o,
  input  wire        tx_ready_i,
  output reg  [10:0] tx_id_o,
  output reg  [3:0]  tx_len_o,
  output reg  [63:0] tx_data_o
);

  // ----------------------------------------------------------------
  // configuration tables
  // ----------------------------------------------------------------
  localparam AW = 8;
  reg [7:0]  mem_r   [0:NSLV*256-1];
  reg [10:0] rid_r   [0:NENT-1];
  reg [3:0]  rlen_r  [0:NENT-1];
  reg [7:0]  rslv_r  [0:NENT-1];
  reg [63:0] rslot_r [0:NENT-1];
  reg [15:0] rto_r   [0:NENT-1];
  reg        ren_r   [0:NENT-1];
  reg [15:0] rage_r  [0:NENT-1];
  reg [10:0] tid_r   [0:NENT-1];
  reg [3:0]  tlen_r  [0:NENT-1];
  reg [7:0]  tslv_r  [0:NENT-1];
  reg [63:0] tslot_r [0:NENT-1];
  reg [15:0] tper_r  [0:NENT-1];
  reg        tchg_r  [0:NENT-1];
  reg        ten_r   [0:NENT-1];
  reg [15:0] tage_r  [0:NENT-1];
  reg [63:0] tlast_r [0:NENT-1];

  reg        en_r;
  reg        bad_r;
  reg [7:0]  sel_r;
  reg [15:0] memadr_r;
  reg [15:0] rxcnt_r;
  reg [15:0] txcnt_r;
  reg [15:0] mscnt_r;
  reg        tick_r;

  function len_ok;
    input [3:0] len;
    begin
      len_ok = (len >= `PDOM_LEN_MIN) && (len <= `PDOM_LEN_MAX);
    end
  endfunction

  function [9:0] maddr;
    input [7:0] slv;
    input [7:0] slot;
    begin
      maddr = {slv[1:0], slot};
    end
  endfunction

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  localparam S_IDLE  = 3'h0;
  localparam S_RXWR  = 3'h1;
  localparam S_CLR   = 3'h2;
  localparam S_TXRD  = 3'h3;
  localparam S_TXOUT = 3'h4;
  localparam S_SCAN  = 3'h5;

  reg [2:0]  st_r;
  reg [4:0]  ent_r;
  reg [3:0]  bidx_r;
  reg [63:0] buf_r;
  reg [63:0] rxd_r;
  reg        rxpend_r;
  reg [10:0] rxid_r;
  reg [4:0]  scan_r;
  reg        agepend_r;

  wire apb_acc = psel_i & penable_i & ~pready_o;
  wire apb_wr  = apb_acc & pwrite_i;
  wire sel_tx  = sel_r[`PDOM_SEL_TX_BIT];
  wire [4:0] sel_i = sel_r[4:0];
  wire sel_ok  = sel_r[4:0] < NENT;

  // ----------------------------------------------------------------
  // receive match, lowest entry wins
  // ----------------------------------------------------------------
  reg        hit;
  reg [4:0]  hit_idx;
  integer    k;
  always @* begin
    hit = 1'b0;
    hit_idx = 5'h00;
    for (k = NENT - 1; k >= 0; k = k - 1) begin
      if (ren_r[k] && len_ok(rlen_r[k]) && rid_r[k] == rxid_r) begin
        hit = 1'b1;
        hit_idx = k[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // apb register read mux
  // ----------------------------------------------------------------
  reg [31:0] rd;
  reg        rd_err;
  always @* begin
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr_i)
      `PDOM_CTRL_ADDR:   rd = {31'h0, en_r};
      `PDOM_STAT_ADDR:   rd = {30'h0, st_r != S_IDLE, bad_r};
      `PDOM_SEL_ADDR:    rd = {24'h0, sel_r};
      `PDOM_ID_ADDR:     rd = {21'h0, sel_tx ? tid_r[sel_i] : rid_r[sel_i]};
      `PDOM_CFG_ADDR:    rd = sel_tx ? {14'h0, ten_r[sel_i], tchg_r[sel_i], tslv_r[sel_i], 4'h0, tlen_r[sel_i]}
                                     : {14'h0, ren_r[sel_i], 1'b0, rslv_r[sel_i], 4'h0, rlen_r[sel_i]};
      `PDOM_SLOTLO_ADDR: rd = sel_tx ? tslot_r[sel_i][31:0] : rslot_r[sel_i][31:0];
      `PDOM_SLOTHI_ADDR: rd = sel_tx ? tslot_r[sel_i][63:32] : rslot_r[sel_i][63:32];
      `PDOM_TIME_ADDR:   rd = {16'h0, sel_tx ? tper_r[sel_i] : rto_r[sel_i]};
      `PDOM_MEMA_ADDR:   rd = {16'h0, memadr_r};
      `PDOM_MEMD_ADDR:   rd = {24'h0, mem_r[memadr_r[9:0]]};
      `PDOM_RXCNT_ADDR:  rd = {16'h0, rxcnt_r};
      `PDOM_TXCNT_ADDR:  rd = {16'h0, txcnt_r};
      default:           rd_err = 1'b1;
    endcase
    if (!sel_ok && (paddr_i >= `PDOM_ID_ADDR) && (paddr_i <= `PDOM_TIME_ADDR))
      rd_err = 1'b1;
  end

  // ----------------------------------------------------------------
  // apb slave: one wait state, answer on second access cycle
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      en_r      <= `PDOM_CTRL_RST;
      sel_r     <= 8'h00;
      memadr_r  <= 16'h0000;
      bad_r     <= 1'b0;
    end else begin
      pready_o  <= apb_acc;
      pslverr_o <= apb_acc & rd_err;
      prdata_o  <= (apb_acc & ~pwrite_i & ~rd_err) ? rd : 32'h0000_0000;
      if (apb_wr && !rd_err) begin
        case (paddr_i)
          `PDOM_CTRL_ADDR: en_r <= pwdata_i[`PDOM_CTRL_EN_BIT];
          `PDOM_SEL_ADDR:  sel_r <= pwdata_i[7:0];
          `PDOM_MEMA_ADDR: memadr_r <= pwdata_i[15:0];
          `PDOM_STAT_ADDR: bad_r <= bad_r & ~pwdata_i[`PDOM_STAT_BAD_BIT];
          `PDOM_CFG_ADDR: begin
            if (!len_ok(pwdata_i[3:0]) && pwdata_i[`PDOM_CFG_EN_BIT])
              bad_r <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // table writes; invalid length leaves the entry disabled
  always @(posedge ref_clk_i) begin
    if (apb_wr && !rd_err) begin
      case (paddr_i)
        `PDOM_ID_ADDR:
          if (sel_tx) tid_r[sel_i] <= pwdata_i[10:0];
          else rid_r[sel_i] <= pwdata_i[10:0];
        `PDOM_CFG_ADDR:
          if (sel_tx) begin
            tlen_r[sel_i] <= pwdata_i[3:0];
            tslv_r[sel_i] <= pwdata_i[15:8];
            tchg_r[sel_i] <= pwdata_i[`PDOM_CFG_CHG_BIT];
          end else begin
            rlen_r[sel_i] <= pwdata_i[3:0];
            rslv_r[sel_i] <= pwdata_i[15:8];
          end
        `PDOM_SLOTLO_ADDR:
          if (sel_tx) tslot_r[sel_i][31:0] <= pwdata_i;
          else rslot_r[sel_i][31:0] <= pwdata_i;
        `PDOM_SLOTHI_ADDR:
          if (sel_tx) tslot_r[sel_i][63:32] <= pwdata_i;
          else rslot_r[sel_i][63:32] <= pwdata_i;
        `PDOM_TIME_ADDR:
          if (sel_tx) tper_r[sel_i] <= pwdata_i[15:0];
          else rto_r[sel_i] <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // enables need a reset value; kept apart from the bulk tables
  integer e;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (e = 0; e < NENT; e = e + 1) begin
        ren_r[e] <= 1'b0;
        ten_r[e] <= 1'b0;
      end
    end else if (apb_wr && !rd_err && paddr_i == `PDOM_CFG_ADDR) begin
      if (sel_tx) ten_r[sel_i] <= pwdata_i[`PDOM_CFG_EN_BIT] & len_ok(pwdata_i[3:0]);
      else ren_r[sel_i] <= pwdata_i[`PDOM_CFG_EN_BIT] & len_ok(pwdata_i[3:0]);
    end
  end

  // ----------------------------------------------------------------
  // millisecond time base
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mscnt_r <= 16'h0000;
      tick_r  <= 1'b0;
    end else begin
      tick_r  <= (mscnt_r == MS_CYC - 1);
      mscnt_r <= (mscnt_r == MS_CYC - 1) ? 16'h0000 : mscnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // sequencer: receive copy, timeout clear, periodic/change transmit
  // ----------------------------------------------------------------
  wire [7:0] rslot = rslot_r[ent_r][bidx_r*8 +: 8];
  wire [7:0] tslot = tslot_r[scan_r][bidx_r*8 +: 8];
  wire [7:0] mrd   = mem_r[maddr(tslv_r[scan_r], tslot)];
  wire       tmo   = rto_r[scan_r] != 16'h0000 && rage_r[scan_r] >= rto_r[scan_r];
  wire       per   = tper_r[scan_r] != 16'h0000 && tage_r[scan_r] >= tper_r[scan_r];
  wire       chg   = tchg_r[scan_r] && (buf_r != tlast_r[scan_r]);

  integer a;
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r       <= S_IDLE;
      ent_r      <= 5'h00;
      bidx_r     <= 4'h0;
      buf_r      <= 64'h0;
      rxd_r      <= 64'h0;
      rxid_r     <= 11'h000;
      rxpend_r   <= 1'b0;
      scan_r     <= 5'h00;
      agepend_r  <= 1'b0;
      rxcnt_r    <= 16'h0000;
      txcnt_r    <= 16'h0000;
      tx_valid_o <= 1'b0;
      tx_id_o    <= 11'h000;
      tx_len_o   <= 4'h0;
      tx_data_o  <= 64'h0;
      for (a = 0; a < NENT; a = a + 1) begin
        rage_r[a]  <= 16'h0000;
        tage_r[a]  <= 16'h0000;
        tlast_r[a] <= 64'h0;
      end
    end else begin
      // a frame arriving while one is pending is dropped; the bus rate leaves ample time
      if (rx_valid_i && !rxpend_r && en_r) begin
        rxpend_r <= 1'b1;
        rxid_r   <= rx_id_i;
        rxd_r    <= rx_data_i;
      end
      if (tx_valid_o && tx_ready_i)
        tx_valid_o <= 1'b0;
      case (st_r)
        S_IDLE: begin
          bidx_r <= 4'h0;
          if (rxpend_r) begin
            rxpend_r <= 1'b0;
            if (hit) begin
              ent_r <= hit_idx;
              st_r  <= S_RXWR;
            end
          end else if (agepend_r) begin
            agepend_r <= 1'b0;
            for (a = 0; a < NENT; a = a + 1) begin
              if (rage_r[a] != 16'hFFFF) rage_r[a] <= rage_r[a] + 16'h0001;
              if (tage_r[a] != 16'hFFFF) tage_r[a] <= tage_r[a] + 16'h0001;
            end
            scan_r <= 5'h00;
            st_r   <= en_r ? S_SCAN : S_IDLE;
          end
        end
        S_RXWR: begin
          if (bidx_r < rlen_r[ent_r])
            mem_r[maddr(rslv_r[ent_r], rslot)] <= rxd_r[bidx_r*8 +: 8];
          if (bidx_r == 4'h7) begin
            rage_r[ent_r] <= 16'h0000;
            rxcnt_r <= rxcnt_r + 16'h0001;
            st_r <= S_IDLE;
          end
          bidx_r <= bidx_r + 4'h1;
        end
        S_SCAN: begin
          bidx_r <= 4'h0;
          ent_r  <= scan_r;
          buf_r  <= 64'h0;
          if (ren_r[scan_r] && tmo) begin
            st_r <= S_CLR;
          end else if (ten_r[scan_r]) begin
            st_r <= S_TXRD;
          end else if (scan_r == NENT - 1) begin
            st_r <= S_IDLE;
          end else begin
            scan_r <= scan_r + 5'h01;
          end
        end
        S_CLR: begin
          if (bidx_r < rlen_r[ent_r])
            mem_r[maddr(rslv_r[ent_r], rslot)] <= 8'h00;
          // restart the byte index so the transmit read that follows fetches all slots
          if (bidx_r == 4'h7) begin
            rage_r[ent_r] <= 16'h0000;
            bidx_r <= 4'h0;
            st_r <= ten_r[scan_r] ? S_TXRD : S_TXOUT;
          end else begin
            bidx_r <= bidx_r + 4'h1;
          end
        end
        S_TXRD: begin
          if (bidx_r[3]) begin
            st_r <= S_TXOUT;
          end else begin
            if (bidx_r < tlen_r[scan_r])
              buf_r[bidx_r*8 +: 8] <= mrd;
            bidx_r <= bidx_r + 4'h1;
          end
        end
        S_TXOUT: begin
          if (ten_r[scan_r] && (per || chg) && !tx_valid_o) begin
            tx_valid_o <= 1'b1;
            tx_id_o    <= tid_r[scan_r];
            tx_len_o   <= tlen_r[scan_r];
            tx_data_o  <= buf_r;
            tlast_r[scan_r] <= buf_r;
            tage_r[scan_r]  <= 16'h0000;
            txcnt_r <= txcnt_r + 16'h0001;
          end
          // wait for the link before sending; while a triggered frame waits, the scan holds in S_TXOUT
          if (!(ten_r[scan_r] && (per || chg) && tx_valid_o)) begin
            if (scan_r == NENT - 1) begin
              st_r <= S_IDLE;
            end else begin
              scan_r <= scan_r + 5'h01;
              st_r <= S_SCAN;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
      // a tick in the same cycle as the idle clear must not be lost: set wins
      if (tick_r)
        agepend_r <= 1'b1;
    end
  end

endmodule

//--- bench/pdom_mapper_properties.sv
// concurrent checks on the ports of the process data object mapper
`timescale 1ns/1ps
module pdom_mapper_properties (
  // clock and reset
  input wire        ref_clk_i,
  input wire        rst_i,
  // apb slave
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  // can frames
  input wire        rx_valid_i,
  input wire [10:0] rx_id_i,
  input wire [63:0] rx_data_i,
  input wire        tx_valid_o,
  input wire        tx_ready_i,
  input wire [10:0] tx_id_o,
  input wire [3:0]  tx_len_o,
  input wire [63:0] tx_data_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  AST_APB_WAIT: assert property ($rose(psel_i && penable_i) |=> pready_o) else $error("pready not one wait state");
  AST_APB_PULSE: assert property (pready_o |=> !pready_o) else $error("pready longer than one cycle");
  AST_APB_CAUSE: assert property (pready_o |-> psel_i && penable_i && $past(psel_i && penable_i))
    else $error("pready without access");
  AST_ERR_PAIR: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside answer");

  // ----------------------------------------------------------------
  // transmit frames
  // ----------------------------------------------------------------
  AST_TX_HOLD: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_id_o, tx_len_o, tx_data_o}))
    else $error("frame changed before acceptance");
  AST_TX_LEN: assert property (tx_valid_o |-> tx_len_o >= 4'h1 && tx_len_o <= 4'h8)
    else $error("frame length out of range");
  AST_TX_PAD: assert property (tx_valid_o |-> (tx_data_o >> {tx_len_o, 3'h0}) == 64'h0)
    else $error("bytes beyond length not zero");
  AST_TX_ONCE: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
    else $error("frame repeated after acceptance");

  COV_TX_DONE: cover property (tx_valid_o && tx_ready_i);
  COV_TX_STALL: cover property (tx_valid_o && !tx_ready_i ##1 tx_valid_o);
  COV_APB_ERR: cover property (pready_o && pslverr_o);
endmodule

bind pdom_mapper pdom_mapper_properties u_props (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_valid_i, .rx_id_i, .rx_data_i, .tx_valid_o, .tx_ready_i,
  .tx_id_o, .tx_len_o, .tx_data_o);

//--- bench/pdom_can_node.sv
// behavioural can network node facing the mapper
`timescale 1ns/1ps
module pdom_can_node (
  // clock and reset
  input  wire         ref_clk_i,
  input  wire         rst_i,
  // frames toward the mapper
  output logic        rx_valid_o,
  output logic [10:0] rx_id_o,
  output logic [63:0] rx_data_o,
  // frames from the mapper
  input  wire         tx_valid_i,
  output logic        tx_ready_o,
  input  wire  [10:0] tx_id_i,
  input  wire  [3:0]  tx_len_i,
  input  wire  [63:0] tx_data_i
);
  int          stall_cyc = 3;
  int          frame_cnt;
  int          wait_cnt;
  logic [10:0] last_id;
  logic [3:0]  last_len;
  logic [63:0] last_data;

  initial begin
    rx_valid_o = 1'b0;
    rx_id_o = 11'h0;
    rx_data_o = 64'h0;
  end

  task send(input logic [10:0] id, input logic [63:0] data);
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b1;
    rx_id_o <= id;
    rx_data_o <= data;
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b0;
    // idle lines must not look like a held frame
    rx_id_o <= ~id;
    rx_data_o <= ~data;
  endtask

  // slow controller: accepts a frame only after a few busy cycles
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
      wait_cnt <= 0;
      frame_cnt <= 0;
    end else if (tx_valid_i && tx_ready_o) begin
      frame_cnt <= frame_cnt + 1;
      last_id <= tx_id_i;
      last_len <= tx_len_i;
      last_data <= tx_data_i;
      tx_ready_o <= 1'b0;
      wait_cnt <= 0;
    end else if (tx_valid_i) begin
      wait_cnt <= wait_cnt + 1;
      tx_ready_o <= (wait_cnt >= stall_cyc);
    end
  end
endmodule

//--- bench/pdom_mapper_tb.sv
// self-checking testbench of the process data object mapper
`timescale 1ns/1ps
`include "pdom_regs.vh"
module pdom_mapper_tb;
  // one scan of all entries must fit inside a tick, else ticks merge and periods stretch
  localparam int MS = 100;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic        rx_valid, tx_valid, tx_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] rx_id, tx_id;
  logic [63:0] rx_data, tx_data;
  logic [3:0]  tx_len;
  logic [7:0]  exp1 [8] = '{8'hAA, 8'hBB, 8'hCC, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
  int          fail_count, check_count, n0;

  always #25 clk = ~clk;

  pdom_mapper #(.NENT(30), .NSLV(4), .MS_CYC(MS)) dut (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rx_valid_i(rx_valid), .rx_id_i(rx_id), .rx_data_i(rx_data),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_id_o(tx_id), .tx_len_o(tx_len), .tx_data_o(tx_data));
  pdom_can_node node (.ref_clk_i(clk), .rst_i(rst), .rx_valid_o(rx_valid), .rx_id_o(rx_id), .rx_data_o(rx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_id_i(tx_id), .tx_len_i(tx_len), .tx_data_i(tx_data));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 16);
    if (i >= 16) begin
      fail_count++;
      $display("wrong value at %0t: bus timeout", $time);
      summarize;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp); apb(1'b0, a, 32'h0); check(rd, exp); endtask
  task ent(input logic [7:0] sel, input logic [10:0] id, input logic [31:0] cfg, lo, hi, tm);
    wr(`PDOM_SEL_ADDR, sel); wr(`PDOM_ID_ADDR, id); wr(`PDOM_SLOTLO_ADDR, lo);
    wr(`PDOM_SLOTHI_ADDR, hi); wr(`PDOM_TIME_ADDR, tm); wr(`PDOM_CFG_ADDR, cfg);
  endtask
  task memchk(input logic [9:0] a, input logic [7:0] exp);
    wr(`PDOM_MEMA_ADDR, a); apb(1'b0, `PDOM_MEMD_ADDR, 32'h0); check(rd[7:0], exp);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdchk(`PDOM_CTRL_ADDR, 32'h0);
    rdchk(12'h030, 32'h0); check(er, 1'b1);
    wr(`PDOM_SEL_ADDR, 32'h1E); apb(1'b1, `PDOM_ID_ADDR, 32'h123); check(er, 1'b1);
    wr(`PDOM_SEL_ADDR, 32'h1D); wr(`PDOM_ID_ADDR, 32'h123); rdchk(`PDOM_ID_ADDR, 32'h123);
    wr(`PDOM_SEL_ADDR, 32'h9D); wr(`PDOM_ID_ADDR, 32'h456); rdchk(`PDOM_ID_ADDR, 32'h456);
    wr(`PDOM_SEL_ADDR, 32'h9E); apb(1'b0, `PDOM_ID_ADDR, 32'h0); check(er, 1'b1);
    ent(8'h81, 11'h3FF, 32'h0002_0109, 32'h0, 32'h0, 32'h1); apb(1'b0, `PDOM_STAT_ADDR, 32'h0); check(rd[0], 1'b1);
    wr(`PDOM_STAT_ADDR, 32'h1); apb(1'b0, `PDOM_STAT_ADDR, 32'h0); check(rd[0], 1'b0);
    ent(8'h82, 11'h3FE, 32'h0002_0100, 32'h0, 32'h0, 32'h1); apb(1'b0, `PDOM_STAT_ADDR, 32'h0); check(rd[0], 1'b1);
    $display("test registers and lengths done");
    ent(8'h00, 11'h181, 32'h0002_0103, 32'h1312_1110, 32'h1716_1514, 32'h0);
    ent(8'h01, 11'h201, 32'h0002_0108, 32'h1312_1110, 32'h1716_1514, 32'h0);
    ent(8'h02, 11'h281, 32'h0002_0202, 32'h0000_2120, 32'h0, 32'h3);
    wr(`PDOM_CTRL_ADDR, 32'h1);
    repeat (3 * MS) @(posedge clk);
    check(node.frame_cnt, 64'h0);
    node.send(11'h201, 64'h8877_6655_4433_2211); repeat (60) @(posedge clk);
    node.send(11'h181, 64'hFFFF_FFFF_DDCC_BBAA); repeat (60) @(posedge clk);
    node.send(11'h7FF, 64'h0102_0304_0506_0708); repeat (60) @(posedge clk);
    rdchk(`PDOM_RXCNT_ADDR, 32'h2);
    for (int i = 0; i < 8; i++) memchk(10'h110 + i, exp1[i]);
    $display("test receive done");
    n0 = node.frame_cnt;
    ent(8'h80, 11'h301, 32'h0002_0105, 32'h1312_1110, 32'h0000_0014, 32'h4);
    repeat (20 * MS) @(posedge clk);
    check((node.frame_cnt - n0) >= 4 && (node.frame_cnt - n0) <= 6, 1'b1);
    check({node.last_id, node.last_len}, {11'h301, 4'h5});
    check(node.last_data, 64'h0000_0055_44CC_BBAA);
    wr(`PDOM_SEL_ADDR, 32'h80); wr(`PDOM_CFG_ADDR, 32'h0000_0105);
    $display("test periodic send done");
    ent(8'h81, 11'h302, 32'h0003_0202, 32'h0000_2120, 32'h0, 32'h0);
    repeat (2 * MS) @(posedge clk);
    n0 = node.frame_cnt;
    node.send(11'h281, 64'h0000_0000_0000_5AA5);
    repeat (2 * MS) @(posedge clk);
    check(node.frame_cnt - n0, 64'h1);
    check({node.last_id, node.last_data}, {11'h302, 64'h5AA5});
    repeat (6 * MS) @(posedge clk);
    check(node.frame_cnt - n0, 64'h2);
    check(node.last_data, 64'h0);
    memchk(10'h220, 8'h0);
    for (int i = 0; i < 8; i++) memchk(10'h110 + i, exp1[i]);
    $display("test change send and timeout done");
    summarize;
  end
endmodule
